// File: core/fcb_branch_decoder.sv
// Flag conditional relative branch decoder with its taken and fall-through timing.
//
// Notes on behaviour
// RULE_01 - The displacement is an 8-bit two's complement value from -128 to 127.
// RULE_02 - On a taken branch the signed displacement is doubled and added to the counter.
// RULE_03 - The target is the branch address plus 2 plus twice the displacement.
// RULE_04 - A branch is one word, one instruction cycle if not taken and two if taken.
// RULE_05 - A failed condition leaves the counter at the word right after the branch.
// RULE_06 - Branch on carry clear jumps only when the carry flag is 0.
// RULE_07 - Branch on carry clear is recognised by upper byte 1110 0011.
// RULE_08 - Branch on negative clear jumps only when the negative flag is 0.
// RULE_09 - Branch on negative clear is recognised by upper byte 1110 0111.
// RULE_10 - Branch on negative set, upper byte 1110 0110, jumps only when negative is 1.
// RULE_11 - Overflow clear is 1110 0101, zero clear is 1110 0001, and no flag is altered.
// RULE_12 - A taken branch writes the counter in Q4 and then runs one all-idle cycle.
`timescale 1ns/1ps
`include "fcb_map.svh"

module fcb_branch_decoder (
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire logic [`FCB_WORD_W-1:0] instr_word,
  input  wire logic                   instr_valid,
  input  wire logic [`FCB_PC_W-1:0]   pc_inc,
  input  wire fcb_pkg::fcb_flags_s    flags_in,
  output fcb_pkg::fcb_phase_e         q_phase,
  output fcb_pkg::fcb_ctl_s           ctl_r,
  output logic [`FCB_PC_W-1:0]        pc_next_r
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic fcb_pkg::fcb_op_e op_decode(input logic [`FCB_DISP_W-1:0] opc);
    fcb_pkg::fcb_op_e op;
    op = fcb_pkg::op_none;
    if (opc == `FCB_OPC_BCC) begin
      op = fcb_pkg::op_carry_clr; // RULE_07
    end else if (opc == `FCB_OPC_BNGC) begin
      op = fcb_pkg::op_neg_clr; // RULE_09
    end else if (opc == `FCB_OPC_BNS) begin
      op = fcb_pkg::op_neg_set; // RULE_10
    end else if (opc == `FCB_OPC_BOC) begin
      op = fcb_pkg::op_ovf_clr; // RULE_11
    end else if (opc == `FCB_OPC_BZC) begin
      op = fcb_pkg::op_zero_clr; // RULE_11
    end
    return op;
  endfunction

  function automatic logic cond_eval(input fcb_pkg::fcb_op_e op,
                                     input fcb_pkg::fcb_flags_s fl);
    logic ok;
    ok = 1'b0;
    case (op)
      fcb_pkg::op_carry_clr: ok = !fl.carry; // RULE_06
      fcb_pkg::op_neg_clr:   ok = !fl.neg; // RULE_08
      fcb_pkg::op_neg_set:   ok = fl.neg; // RULE_10
      fcb_pkg::op_ovf_clr:   ok = !fl.ovf; // RULE_11
      fcb_pkg::op_zero_clr:  ok = !fl.zero; // RULE_11
      default:               ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Sign extends the 8-bit literal and doubles it, so every target stays word aligned.
  function automatic logic [`FCB_PC_W-1:0] disp_x2(input logic [`FCB_DISP_W-1:0] d);
    return {{(`FCB_PC_W-`FCB_DISP_W-1){d[`FCB_DISP_MSB]}}, d, 1'b0}; // RULE_01 RULE_02
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  fcb_pkg::fcb_state_e      state_r;
  fcb_pkg::fcb_state_e      state_nxt;
  fcb_pkg::fcb_op_e         op_r;
  fcb_pkg::fcb_op_e         op_nxt;
  logic [`FCB_DISP_W-1:0]   disp_r;
  logic [`FCB_PC_W-1:0]     pc_base_r;
  logic [`FCB_PC_W-1:0]     target_r;
  logic [`FCB_PC_W-1:0]     target_sum;
  logic [`FCB_PC_W-1:0]     pc_next_nxt;
  fcb_pkg::fcb_ctl_s        ctl_nxt;
  logic                     exec_q;
  logic                     capture;
  logic                     calc;
  logic                     decide;
  logic                     cond_ok;
  logic                     take;
  logic                     last_q4;

  fcb_qphase u_qphase (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .phase_r (q_phase)
  );

  // ****************************************************************
  // Decode and selection
  // ****************************************************************
  // The fetched word is ignored during the idle cycle, which discards the prefetch.
  assign exec_q      = (state_r == fcb_pkg::st_exec); // RULE_12
  assign capture     = exec_q && (q_phase == fcb_pkg::ph_q1);
  assign calc        = exec_q && (q_phase == fcb_pkg::ph_q2);
  assign decide      = exec_q && (q_phase == fcb_pkg::ph_q3) && (op_r != fcb_pkg::op_none);
  assign op_nxt      = instr_valid ?
                       op_decode(instr_word[`FCB_OPC_MSB:`FCB_OPC_LSB]) : fcb_pkg::op_none;
  assign target_sum  = pc_base_r + disp_x2(disp_r); // RULE_02 RULE_03
  assign cond_ok     = cond_eval(op_r, flags_in);
  assign take        = decide && cond_ok;
  assign last_q4     = !exec_q && (q_phase == fcb_pkg::ph_q4);
  assign pc_next_nxt = decide ? (cond_ok ? target_r : pc_base_r) : pc_next_r; // RULE_05
  assign state_nxt   = (exec_q && (q_phase == fcb_pkg::ph_q4) && ctl_r.taken) ?
                       fcb_pkg::st_squash :
                       (last_q4 ? fcb_pkg::st_exec : state_r); // RULE_04
  assign ctl_nxt     = '{pc_we:  take, // RULE_12
                         squash: (state_nxt == fcb_pkg::st_squash), // RULE_12
                         done:   (decide && !cond_ok) ||
                                 (!exec_q && (q_phase == fcb_pkg::ph_q3)), // RULE_04
                         taken:  take || (ctl_r.taken && !last_q4)};

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      op_r      <= fcb_pkg::op_none;
      disp_r    <= `FCB_DISP_RST;
      pc_base_r <= `FCB_PC_RST;
    end else if (capture) begin
      op_r      <= op_nxt;
      disp_r    <= instr_word[`FCB_DISP_W-1:0];
      pc_base_r <= pc_inc;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      target_r <= `FCB_PC_RST;
    end else if (calc) begin
      target_r <= target_sum;
    end
  end

  // Flags are only read, never written, so the arithmetic datapath keeps ownership of them.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= fcb_pkg::st_exec;
      ctl_r     <= '0;
      pc_next_r <= `FCB_PC_RST;
    end else begin
      state_r   <= state_nxt;
      ctl_r     <= ctl_nxt;
      pc_next_r <= pc_next_nxt;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [`FCB_PC_W-1:0] jump_delta;
  assign jump_delta = pc_next_r - pc_base_r;

  a_disp_span: assert property ( // RULE_01
    @(posedge sys_clk) disable iff (!reset_n)
    ctl_r.pc_we |-> (!jump_delta[0] && ($signed(jump_delta) >= `FCB_SPAN_MIN) &&
                     ($signed(jump_delta) <= `FCB_SPAN_MAX)))
    else $error("Branch span outside the doubled displacement range.");

  a_target_calc: assert property ( // RULE_02 RULE_03
    @(posedge sys_clk) disable iff (!reset_n)
    ctl_r.pc_we |-> ($signed(jump_delta) == (2 * $signed(disp_r))))
    else $error("Taken target is not counter plus twice the displacement.");

  a_cycle_count: assert property ( // RULE_04
    @(posedge sys_clk) disable iff (!reset_n)
    ctl_r.pc_we |-> ##4 (ctl_r.done && ctl_r.taken))
    else $error("Taken branch did not finish after its second cycle.");

  a_single_cycle: assert property ( // RULE_04
    @(posedge sys_clk) disable iff (!reset_n)
    (decide && !cond_ok) |=> (ctl_r.done && !ctl_r.pc_we) ##1 !ctl_r.squash)
    else $error("Untaken branch did not finish in one cycle.");

  a_fall_through: assert property ( // RULE_05
    @(posedge sys_clk) disable iff (!reset_n)
    (ctl_r.done && !ctl_r.taken) |-> (pc_next_r == pc_base_r))
    else $error("Untaken branch did not continue at the next word.");

  a_carry_clear: assert property ( // RULE_06
    @(posedge sys_clk) disable iff (!reset_n)
    (decide && (op_r == fcb_pkg::op_carry_clr)) |=> (ctl_r.pc_we == !$past(flags_in.carry)))
    else $error("Carry clear branch taken against the carry flag.");

  a_decode_carry: assert property ( // RULE_07
    @(posedge sys_clk) disable iff (!reset_n)
    (capture && instr_valid && (instr_word[`FCB_OPC_MSB:`FCB_OPC_LSB] == `FCB_OPC_BCC))
    |=> (op_r == fcb_pkg::op_carry_clr))
    else $error("Carry clear opcode not recognised.");

  a_neg_clear: assert property ( // RULE_08
    @(posedge sys_clk) disable iff (!reset_n)
    (decide && (op_r == fcb_pkg::op_neg_clr)) |=> (ctl_r.pc_we == !$past(flags_in.neg)))
    else $error("Negative clear branch taken against the negative flag.");

  a_decode_neg: assert property ( // RULE_09
    @(posedge sys_clk) disable iff (!reset_n)
    (capture && instr_valid && (instr_word[`FCB_OPC_MSB:`FCB_OPC_LSB] == `FCB_OPC_BNGC))
    |=> (op_r == fcb_pkg::op_neg_clr))
    else $error("Negative clear opcode not recognised.");

  a_neg_set: assert property ( // RULE_10
    @(posedge sys_clk) disable iff (!reset_n)
    (decide && (op_r == fcb_pkg::op_neg_set)) |=> (ctl_r.pc_we == $past(flags_in.neg)))
    else $error("Negative set branch taken against the negative flag.");

  a_ovf_zero: assert property ( // RULE_11
    @(posedge sys_clk) disable iff (!reset_n)
    (decide && ((op_r == fcb_pkg::op_ovf_clr) || (op_r == fcb_pkg::op_zero_clr)))
    |=> (ctl_r.pc_we == ($past(op_r) == fcb_pkg::op_ovf_clr ?
                         !$past(flags_in.ovf) : !$past(flags_in.zero))))
    else $error("Overflow or zero clear branch taken against its flag.");

  a_idle_cycle: assert property ( // RULE_12
    @(posedge sys_clk) disable iff (!reset_n)
    ctl_r.pc_we |-> (q_phase == fcb_pkg::ph_q4) ##1 (ctl_r.squash && !ctl_r.pc_we)[*4]
                    ##1 !ctl_r.squash)
    else $error("Taken branch idle cycle misplaced.");

endmodule // fcb_branch_decoder

// File: core/fcb_qphase.sv
// Four phase sequencer that splits each instruction cycle into Q1 to Q4.
`timescale 1ns/1ps

module fcb_qphase (
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  output fcb_pkg::fcb_phase_e phase_r
);

  fcb_pkg::fcb_phase_e phase_nxt;

  always_comb begin
    case (phase_r)
      fcb_pkg::ph_q1: phase_nxt = fcb_pkg::ph_q2;
      fcb_pkg::ph_q2: phase_nxt = fcb_pkg::ph_q3;
      fcb_pkg::ph_q3: phase_nxt = fcb_pkg::ph_q4;
      default:        phase_nxt = fcb_pkg::ph_q1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= fcb_pkg::ph_q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

endmodule // fcb_qphase

// File: shared/fcb_map.svh
// Constants for the flag conditional relative branch decoder.
`ifndef FCB_MAP_SVH
`define FCB_MAP_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define FCB_PC_W      21
`define FCB_WORD_W    16
`define FCB_DISP_W    8
`define FCB_OPC_MSB   15
`define FCB_OPC_LSB   8
`define FCB_DISP_MSB  7

// ****************************************************************
// Opcode upper bytes
// ****************************************************************
`define FCB_OPC_BZC   8'he1
`define FCB_OPC_BCC   8'he3
`define FCB_OPC_BOC   8'he5
`define FCB_OPC_BNS   8'he6
`define FCB_OPC_BNGC  8'he7

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define FCB_PC_RST    21'h000000
`define FCB_DISP_RST  8'h00
`define FCB_SPAN_MIN  (-256)
`define FCB_SPAN_MAX  254

`endif

// File: shared/fcb_pkg.sv
// Types shared by the flag conditional relative branch decoder.
`include "fcb_map.svh"

package fcb_pkg;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {ph_q1, ph_q2, ph_q3, ph_q4} fcb_phase_e;

  typedef enum logic {st_exec, st_squash} fcb_state_e;

  typedef enum logic [2:0] {
    op_none,
    op_neg_set,
    op_carry_clr,
    op_neg_clr,
    op_ovf_clr,
    op_zero_clr
  } fcb_op_e;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic carry;
  } fcb_flags_s;

  typedef struct packed {
    logic pc_we;
    logic squash;
    logic done;
    logic taken;
  } fcb_ctl_s;

endpackage

// File: testbench/fcb_fetch_model.sv
// Fetch side model that keeps the program counter steered by the decoder.
`timescale 1ns/1ps
`include "fcb_map.svh"

module fcb_fetch_model #(
  parameter logic [`FCB_PC_W-1:0] START_PC = 21'h000100
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire fcb_pkg::fcb_phase_e  q_phase,
  input  wire fcb_pkg::fcb_ctl_s    ctl_r,
  input  wire logic [`FCB_PC_W-1:0] pc_next_r,
  output logic [`FCB_PC_W-1:0]      pc_inc
);
  logic [`FCB_PC_W-1:0] pc_r;

  // The counter moves only at the end of Q4, so a word and its address stay paired.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_r <= START_PC;
    end else if (q_phase == fcb_pkg::ph_q4) begin
      if (ctl_r.pc_we) begin
        pc_r <= pc_next_r;
      end else if (!ctl_r.squash) begin
        pc_r <= pc_r + 21'h000002;
      end
    end
  end

  assign pc_inc = pc_r + 21'h000002;
endmodule // fcb_fetch_model

// File: testbench/flag_conditional_rel_branch_tb.sv
// Self-checking bench for the flag conditional relative branch decoder.
`timescale 1ns/1ps
`include "fcb_map.svh"

module flag_conditional_rel_branch_tb;
  logic                   sys_clk;
  logic                   reset_n;
  logic [`FCB_WORD_W-1:0] instr_word;
  logic                   instr_valid;
  logic [`FCB_PC_W-1:0]   pc_inc;
  fcb_pkg::fcb_flags_s    flags_in;
  fcb_pkg::fcb_phase_e    q_phase;
  fcb_pkg::fcb_ctl_s      ctl_r;
  logic [`FCB_PC_W-1:0]   pc_next_r;
  logic [15:0]            lfsr;
  int                     errors;
  int                     comparisons;
  logic [7:0]             opc_tab [6];

  always #2 sys_clk = ~sys_clk;

  fcb_branch_decoder dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .instr_word(instr_word),
    .instr_valid(instr_valid), .pc_inc(pc_inc), .flags_in(flags_in), .q_phase(q_phase),
    .ctl_r(ctl_r), .pc_next_r(pc_next_r));

  fcb_fetch_model model_u (.sys_clk(sys_clk), .reset_n(reset_n), .q_phase(q_phase),
    .ctl_r(ctl_r), .pc_next_r(pc_next_r), .pc_inc(pc_inc));

  // ****************************************************************
  // Expectations
  // ****************************************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Returns a pair: is a branch, and jumps.
  function automatic logic [1:0] exp_kind(input logic [7:0] o, input fcb_pkg::fcb_flags_s f);
    case (o)
      `FCB_OPC_BZC: return {1'b1, !f.zero};
      `FCB_OPC_BCC: return {1'b1, !f.carry};
      `FCB_OPC_BOC: return {1'b1, !f.ovf};
      `FCB_OPC_BNS: return {1'b1, f.neg};
      `FCB_OPC_BNGC: return {1'b1, !f.neg};
      default: return 2'h0;
    endcase
  endfunction

  function automatic logic [`FCB_PC_W-1:0] exp_target(input logic [`FCB_PC_W-1:0] pc,
                                                       input logic [7:0] d);
    return pc + {{12{d[7]}}, d, 1'b0};
  endfunction

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wait_q4();
    int n;
    n = 0;
    while (q_phase !== fcb_pkg::ph_q4) begin
      @(negedge sys_clk);
      n++;
      if (n > 8) begin
        chk(1'b0, "phase stuck");
        stop_test();
      end
    end
  endtask

  // Presents one word in the Q1 slot and checks the whole instruction.
  task automatic run(input logic v, input logic [15:0] w, input fcb_pkg::fcb_flags_s f);
    logic [1:0]           k;
    logic [`FCB_PC_W-1:0] exp_pc;
    k = exp_kind(w[15:8], f) & {v, v};
    exp_pc = pc_next_r;
    wait_q4();
    @(posedge sys_clk);
    instr_valid <= v;
    instr_word  <= w;
    flags_in    <= f;
    @(negedge sys_clk);
    chk(ctl_r === 4'h0, "stale control");
    chk(q_phase === fcb_pkg::ph_q1, "phase after setup");
    wait_q4();
    if (k[1]) begin
      exp_pc = k[0] ? exp_target(pc_inc, w[7:0]) : pc_inc;
    end
    chk(ctl_r.done === (k[1] & !k[0]), "done in first cycle");
    chk(ctl_r.pc_we === k[0] && ctl_r.taken === k[0], "write strobe");
    chk(pc_next_r === exp_pc, "next counter");
    if (k[0]) begin
      // A branch that would jump is offered in the idle slot; it must be dropped.
      @(posedge sys_clk);
      instr_word <= {`FCB_OPC_BCC, lfsr[7:0]};
      flags_in   <= '0;
      for (int i = 0; i < 4; i++) begin
        @(negedge sys_clk);
        chk(ctl_r.squash === 1'b1 && ctl_r.pc_we === 1'b0 && pc_next_r === exp_pc,
            "idle cycle");
      end
      chk(ctl_r.done === 1'b1 && ctl_r.taken === 1'b1, "done after idle");
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    instr_word = '0;
    instr_valid = 1'b0;
    flags_in = '0;
    lfsr = 16'h002e;
    errors = 0;
    comparisons = 0;
    opc_tab = '{`FCB_OPC_BZC, `FCB_OPC_BCC, `FCB_OPC_BOC, `FCB_OPC_BNS, `FCB_OPC_BNGC, 8'he2};
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    chk(pc_next_r === `FCB_PC_RST && ctl_r === 4'h0, "reset values");
    foreach (opc_tab[i]) begin
      for (int m = 0; m < 32; m++) begin
        run(1'b1, {opc_tab[i], m[4] ? 8'h80 : 8'h7f}, fcb_pkg::fcb_flags_s'(m[3:0]));
      end
      $display("Test corner opcode %h done", opc_tab[i]);
    end
    run(1'b0, {`FCB_OPC_BNS, 8'h10}, 4'hf);
    for (int i = 0; i < 300; i++) begin
      lfsr = lfsr_next(lfsr);
      run(lfsr[15] | lfsr[12], {opc_tab[int'(lfsr[10:8]) % 6], lfsr[7:0]},
          fcb_pkg::fcb_flags_s'(lfsr[14:11]));
    end
    $display("Test random done");
    stop_test();
  end
endmodule // flag_conditional_rel_branch_tb
